// *** eer_host.sv ***
// eer_host: serial host model, frames one command per cs_n low
// assumes eer_top captures lk_cmd on sck while lk_cmd_v is high
`timescale 1ns/1ns
module eer_host
  import eer_pkg::*;
(
  // link to the device
  output logic       sck,
  output logic       cs_n,
  output logic       lk_cmd_v,
  output logic [7:0] lk_cmd
);
  initial begin
    sck      = 1'b0;
    cs_n     = 1'b1;
    lk_cmd_v = 1'b0;
    lk_cmd   = 8'hA5;
  end
  // command frame; sck stands still outside it
  task automatic start(input logic [7:0] c);
    cs_n    <= 1'b0;
    #7;
    lk_cmd   = c;
    lk_cmd_v = 1'b1;
    repeat (3) begin
      #3 sck = 1'b1;
      #3 sck = 1'b0;
      lk_cmd_v = 1'b0;
      // released code lines keep changing, no stale value
      lk_cmd   = ~lk_cmd;
    end
  endtask
  task automatic stop();
    cs_n <= 1'b1;
  endtask
endmodule

// *** eer_pkg.sv ***
// eer_pkg: constants and types of the ecc error reporting block
// assumes the array read path and command decoder share mclk
package eer_pkg;
  // byte addresses for generic register reads
  localparam logic [31:0] EER_ADR_EVT   = 32'h0080_0089;
  localparam logic [31:0] EER_ADR_TAL0  = 32'h0080_008A;
  localparam logic [31:0] EER_ADR_TAL1  = 32'h0080_008B;
  localparam logic [31:0] EER_ADR_TRP0  = 32'h0080_008E;
  localparam logic [31:0] EER_ADR_TRP1  = 32'h0080_008F;
  localparam logic [31:0] EER_ADR_TRP2  = 32'h0080_0040;
  localparam logic [31:0] EER_ADR_TRP3  = 32'h0080_0041;
  // command codes carried across the link
  localparam logic [7:0] EER_OP_READ    = 8'h03;
  localparam logic [7:0] EER_OP_QUERY   = 8'h18;
  localparam logic [7:0] EER_OP_QUERY2  = 8'h19;
  localparam logic [7:0] EER_OP_CLEAR   = 8'h1B;
  // unit status byte fields
  localparam int        EER_DUS_OFF    = 0;
  localparam int        EER_DUS_SBC    = 1;
  localparam int        EER_DUS_DBD    = 3;
  localparam logic [7:0] EER_DUS_RSVD  = 8'hF4;
  // event status fields
  localparam int        EER_EVT_SBC    = 3;
  localparam int        EER_EVT_DBD    = 4;
  localparam int        EER_UNIT_LSB   = 4;
  // config bit positions
  localparam int        EER_CFG_BIT    = 3;
  // reset values
  localparam logic [7:0]  EER_RST_BYTE = 8'h00;
  localparam logic [15:0] EER_RST_TAL  = 16'h0000;
  localparam logic [15:0] EER_TAL_MAX  = 16'hFFFF;
  localparam logic [31:0] EER_RST_TRP  = 32'h0000_0000;

  typedef enum logic [2:0] {
    EER_IDLE  = 3'b001,
    EER_READ  = 3'b010,
    EER_QUERY = 3'b100
  } eer_mode_t;

  typedef struct packed {
    logic [7:0] hold;
    logic       tog;
  } eer_lnk_t;

  typedef struct packed {
    logic        cs1, cs2, cs3;
    logic        tg1, tg2, tg3;
    eer_mode_t   mode;
    logic [7:0]  evt;
    logic [31:0] trap;
    logic        trp_tk;
    logic [15:0] tal;
    logic [27:0] last;
    logic        last_ok;
    logic [7:0]  dus;
    logic        dus_v;
    logic [7:0]  rdat;
    logic        rhit;
    logic        perr;
    logic        uoff;
  } eer_st_t;
endpackage

// *** eer_top.sv ***
// eer_top: ecc error reporting (unit status, event status, trap, tally)
// assumes: per-unit check results arrive on mclk from the read path;
// command codes arrive on sck from the serial front end; cs_n is a pin
//
// Contract
// (R1) each 16-byte unit single-bit correctable
// (R2) re-program without erase disables unit ecc
// (R3) query returns 8-bit status of unit
// (R4) double flag only when double detection on
// (R5) double detection on: reprogram is error
// (R6) bit 1 flags corrected single error
// (R7) bit 0 flags ecc off for unit
// (R8) bits 7-4 and 2 read zero
// (R9) volatile 8-bit event status register
// (R10) event status updated during array reads
// (R11) event status cleared by resets, clear
// (R12) trap holds first enabled-type error address
// (R13) trap written only during reads
// (R14) several failing units: keep first only
// (R15) trap valid while event bit 3/4
// (R16) trap cleared by resets and clear
// (R17) 16-bit tally counts main-array errors
// (R18) tally changes only on array reads
// (R19) tally saturates at all ones
// (R20) continuous read counts until cs high
// (R21) one count per unit per transaction; code only skips a repeat of the unit just before
// (R22) ecc-off unit: no detect, count, trap; code ignores it only while double detection is off
// (R23) tally zeroed by resets and clear
// (R24) trap and tally readable by register read
// (R25) all three fed by same unit result
`timescale 1ns/1ns
module eer_top
  import eer_pkg::*;
(
  // clocks and resets
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic        sck,
  input  wire logic        cs_n,
  input  wire logic        soft_rst,
  input  wire logic        hw_rst,
  input  wire logic        cs_sig_rst,
  // command code from serial front end (sck domain)
  input  wire logic        lk_cmd_v,
  input  wire logic [7:0]  lk_cmd,
  // configuration
  input  wire logic [7:0]  config_four_volatile,
  input  wire logic [7:0]  config_four_nonvolatile,
  // per-unit check result from read path
  input  wire logic        unit_v,
  input  wire logic [31:0] unit_addr,
  input  wire logic        unit_sbc,
  input  wire logic        unit_dbd,
  input  wire logic        unit_main,
  input  wire logic        unit_off,
  // program path
  input  wire logic        prog_req,
  input  wire logic        prog_dirty,
  output logic             prog_error,
  output logic             unit_off_set,
  // unit status query answer
  output logic [7:0]       data_unit_ecc_status,
  output logic             dus_valid,
  // generic register read
  input  wire logic        rd_req,
  input  wire logic [31:0] rd_addr,
  output logic [7:0]       rd_data,
  output logic             rd_hit,
  // status views
  output logic [7:0]       ecc_event_status,
  output logic [31:0]      error_address_trap,
  output logic [15:0]      error_tally
);

  eer_lnk_t l_r, l_nxt;
  eer_st_t  s_r, s_nxt;

  logic       ded_en, trp_all, clr_rst, cmd_ev;
  logic       cs_rise, clr_any, in_rd, ok_unit;
  logic       sbc_ev, dbd_ev, new_u, cnt_ev, trp_ev;
  logic [7:0] cmd;

  // link side: hold the code and flip a toggle on the same sck edge for the crossing
  always_comb begin
    l_nxt = l_r;
    if (lk_cmd_v) begin
      l_nxt.hold = lk_cmd;
      l_nxt.tog  = ~l_r.tog;
    end
  end

  always_ff @(posedge sck or posedge sys_rst) begin
    if (sys_rst) begin
      l_r <= '0;
    end else begin
      l_r <= l_nxt;
    end
  end

  assign ded_en  = config_four_volatile[EER_CFG_BIT];
  assign trp_all = config_four_nonvolatile[EER_CFG_BIT];
  assign clr_rst = soft_rst | hw_rst | cs_sig_rst;
  assign cmd_ev  = s_r.tg2 ^ s_r.tg3;
  // hold is stable by the time the toggle edge is seen here
  assign cmd     = l_r.hold;
  assign cs_rise = s_r.cs2 & ~s_r.cs3;
  // (R11) clear sources
  assign clr_any = clr_rst | (cmd_ev & (cmd == EER_OP_CLEAR));
  assign in_rd   = (s_r.mode == EER_READ);
  // (R22) ecc-off unit ignored while double detection off
  assign ok_unit = unit_v & ~(unit_off & ~ded_en);
  // (R25) one unit result feeds all
  // (R10) events only on array reads
  // (R1) correction done upstream, flag consumed here
  assign sbc_ev  = in_rd & ok_unit & unit_sbc;
  assign dbd_ev  = in_rd & ok_unit & unit_dbd & ded_en;
  // (R21) one count per run of results from the same unit; only the previous unit is compared
  assign new_u   = ~s_r.last_ok |
                   (unit_addr[31:EER_UNIT_LSB] != s_r.last);
  // (R18) counts need read mode
  // (R17) main array only
  assign cnt_ev  = (sbc_ev | dbd_ev) & new_u & unit_main;
  // (R13) trap only from read events
  // (R12) enabled error type for trap
  assign trp_ev  = dbd_ev | (trp_all & sbc_ev);

  always_comb begin
    s_nxt = s_r;
    s_nxt.cs1   = cs_n;
    s_nxt.cs2   = s_r.cs1;
    s_nxt.cs3   = s_r.cs2;
    s_nxt.tg1   = l_r.tog;
    s_nxt.tg2   = s_r.tg1;
    s_nxt.tg3   = s_r.tg2;
    s_nxt.dus_v = 1'b0;
    s_nxt.rhit  = 1'b0;
    s_nxt.perr  = 1'b0;
    s_nxt.uoff  = 1'b0;
    case (s_r.mode)
      EER_IDLE, EER_READ, EER_QUERY: begin
        // (R20) read stays open until cs high
        if (cs_rise) begin
          s_nxt.mode = EER_IDLE;
        end
        if (cmd_ev) begin
          s_nxt.last_ok = 1'b0;
          if (cmd == EER_OP_READ) begin
            s_nxt.mode = EER_READ;
          end else if (cmd == EER_OP_QUERY || cmd == EER_OP_QUERY2) begin
            s_nxt.mode = EER_QUERY;
          end else begin
            s_nxt.mode = EER_IDLE;
          end
        end
      end
      default: begin
        s_nxt.mode = EER_IDLE;
      end
    endcase
    // (R21) remember unit within transaction
    if (in_rd && unit_v) begin
      s_nxt.last    = unit_addr[31:EER_UNIT_LSB];
      s_nxt.last_ok = 1'b1;
    end
    // (R11) clear, then set wins
    if (clr_any) begin
      s_nxt.evt    = EER_RST_BYTE;
      // (R16) trap cleared too
      s_nxt.trap   = EER_RST_TRP;
      s_nxt.trp_tk = 1'b0;
      // (R23) tally cleared too
      s_nxt.tal    = EER_RST_TAL;
    end
    // (R15) event bit set with trap
    // (R9) sticky event bits
    if (sbc_ev) begin
      s_nxt.evt[EER_EVT_SBC] = 1'b1;
    end
    if (dbd_ev) begin
      s_nxt.evt[EER_EVT_DBD] = 1'b1;
    end
    // (R14) only first failing unit trapped
    if (trp_ev && (!s_r.trp_tk || clr_any)) begin
      s_nxt.trap   = unit_addr;
      s_nxt.trp_tk = 1'b1;
    end
    // (R19) saturating tally
    if (cnt_ev) begin
      if (clr_any) begin
        s_nxt.tal = EER_RST_TAL + 16'h0001;
      end else if (s_r.tal != EER_TAL_MAX) begin
        s_nxt.tal = s_r.tal + 16'h0001;
      end
    end
    // (R3) unit status byte, reserved bits zero
    if (s_r.mode == EER_QUERY && unit_v) begin
      // (R8) reserved bits stay zero
      s_nxt.dus = EER_RST_BYTE;
      // (R4) double flag needs detection
      s_nxt.dus[EER_DUS_DBD] = unit_dbd & ded_en;
      // (R6) corrected single error
      s_nxt.dus[EER_DUS_SBC] = unit_sbc;
      // (R7) unit ecc off
      s_nxt.dus[EER_DUS_OFF] = unit_off;
      s_nxt.dus_v = 1'b1;
    end
    // (R5) double detection forbids reprogramming
    if (prog_req && prog_dirty) begin
      s_nxt.perr = ded_en;
      // (R2) detection off: unit ecc disabled
      s_nxt.uoff = ~ded_en;
    end
    // (R24) generic register read
    if (rd_req) begin
      s_nxt.rhit = 1'b1;
      case (rd_addr)
        EER_ADR_EVT:  s_nxt.rdat = s_r.evt;
        EER_ADR_TAL0: s_nxt.rdat = s_r.tal[7:0];
        EER_ADR_TAL1: s_nxt.rdat = s_r.tal[15:8];
        EER_ADR_TRP0: s_nxt.rdat = s_r.trap[7:0];
        EER_ADR_TRP1: s_nxt.rdat = s_r.trap[15:8];
        EER_ADR_TRP2: s_nxt.rdat = s_r.trap[23:16];
        EER_ADR_TRP3: s_nxt.rdat = s_r.trap[31:24];
        default: begin
          s_nxt.rdat = EER_RST_BYTE;
          s_nxt.rhit = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      s_r      <= '0;
      s_r.cs1  <= 1'b1;
      s_r.cs2  <= 1'b1;
      s_r.cs3  <= 1'b1;
      s_r.mode <= EER_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prog_error           = s_r.perr;
  assign unit_off_set         = s_r.uoff;
  assign data_unit_ecc_status = s_r.dus;
  assign dus_valid            = s_r.dus_v;
  assign rd_data              = s_r.rdat;
  assign rd_hit               = s_r.rhit;
  assign ecc_event_status     = s_r.evt;
  assign error_address_trap   = s_r.trap;
  assign error_tally          = s_r.tal;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  a_tally_sat_top: assert property ( // R19
    (s_r.tal == EER_TAL_MAX && !clr_any) |=> s_r.tal == EER_TAL_MAX)
    else $error("tally left saturation");
  a_tally_step_one: assert property ( // R17
    (cnt_ev && !clr_any && s_r.tal != EER_TAL_MAX)
      |=> s_r.tal == $past(s_r.tal) + 16'h0001)
    else $error("tally did not step by one");
  a_tally_read_only: assert property ( // R18
    (!in_rd && !clr_any) |=> $stable(s_r.tal))
    else $error("tally moved outside read");
  a_trap_hold_first: assert property ( // R14
    (s_r.trp_tk && !clr_any) |=> $stable(s_r.trap))
    else $error("trap overwritten");
  a_trap_take_addr: assert property ( // R12
    (trp_ev && !s_r.trp_tk) |=> s_r.trap == $past(unit_addr) && s_r.trp_tk)
    else $error("trap missed first error");
  a_trap_valid_evt: assert property ( // R15
    s_r.trp_tk |-> (s_r.evt[EER_EVT_SBC] | s_r.evt[EER_EVT_DBD]))
    else $error("trap set without event bit");
  a_dus_rsvd_zero: assert property ( // R8
    (s_r.dus & EER_DUS_RSVD) == EER_RST_BYTE)
    else $error("reserved status bits set");
  a_dus_dbd_gate: assert property ( // R4
    (unit_v && s_r.mode == EER_QUERY && !ded_en)
      |=> dus_valid && !data_unit_ecc_status[EER_DUS_DBD])
    else $error("double flag with detection off");
  a_clear_all_zero: assert property ( // R23
    (clr_any && !unit_v) |=> s_r.tal == EER_RST_TAL && s_r.evt == EER_RST_BYTE
      && s_r.trap == EER_RST_TRP)
    else $error("clear left state");
  a_prog_ded_err: assert property ( // R5
    (prog_req && prog_dirty && ded_en) |=> prog_error && !unit_off_set)
    else $error("reprogram not rejected");
  a_off_unit_quiet: assert property ( // R22
    (unit_v && unit_off && !ded_en && !clr_any) |=> $stable(s_r.tal)
      && $stable(s_r.evt))
    else $error("ecc-off unit counted");

  // event register
  a_evt_sbc_set: assert property ( // R10
    sbc_ev |=> s_r.evt[EER_EVT_SBC])
    else $error("single event bit not set");
  a_evt_dbd_set: assert property ( // R10
    dbd_ev |=> s_r.evt[EER_EVT_DBD])
    else $error("double event bit not set");
  a_evt_no_fall: assert property ( // R9
    !clr_any |=> ($past(s_r.evt) & ~s_r.evt) == EER_RST_BYTE)
    else $error("event bit fell without clear");
  a_evt_read_only: assert property ( // R10
    (!in_rd && !clr_any) |=> $stable(s_r.evt))
    else $error("event moved outside read");

  // trap register
  a_trap_read_only: assert property ( // R13
    (!in_rd && !clr_any) |=> $stable(s_r.trap))
    else $error("trap moved outside read");
  a_trap_clear: assert property ( // R16
    (clr_any && !trp_ev) |=> s_r.trap == EER_RST_TRP && !s_r.trp_tk)
    else $error("trap not cleared");
  a_trap_dbd_only: assert property ( // R12
    (!trp_all && !dbd_ev && !s_r.trp_tk && !clr_any) |=> !s_r.trp_tk)
    else $error("trap took disabled error type");
  a_off_no_trap: assert property ( // R22
    (unit_v && unit_off && !ded_en && !clr_any) |=> $stable(s_r.trap))
    else $error("ecc-off unit trapped");

  // unit status byte
  a_dus_sbc_bit: assert property ( // R6
    (unit_v && s_r.mode == EER_QUERY)
      |=> data_unit_ecc_status[EER_DUS_SBC] == $past(unit_sbc))
    else $error("single flag wrong");
  a_dus_off_bit: assert property ( // R7
    (unit_v && s_r.mode == EER_QUERY)
      |=> data_unit_ecc_status[EER_DUS_OFF] == $past(unit_off))
    else $error("ecc-off flag wrong");
  a_dus_dbd_on: assert property ( // R4
    (unit_v && s_r.mode == EER_QUERY && ded_en)
      |=> data_unit_ecc_status[EER_DUS_DBD] == $past(unit_dbd))
    else $error("double flag wrong");
  a_dus_quiet: assert property ( // R3
    !(unit_v && s_r.mode == EER_QUERY) |=> !dus_valid)
    else $error("status answer without query");

  // program path
  a_prog_off_set: assert property ( // R2
    (prog_req && prog_dirty && !ded_en) |=> unit_off_set && !prog_error)
    else $error("unit ecc not disabled");
  a_prog_quiet: assert property ( // R5
    !(prog_req && prog_dirty) |=> !prog_error && !unit_off_set)
    else $error("program flag without reprogram");

  // tally
  a_tally_main_only: assert property ( // R17
    (unit_v && !unit_main && !clr_any) |=> $stable(s_r.tal))
    else $error("non-main unit counted");
  a_tally_same_unit: assert property ( // R21
    (unit_v && s_r.last_ok && unit_addr[31:EER_UNIT_LSB] == s_r.last && !clr_any)
      |=> $stable(s_r.tal))
    else $error("unit counted twice");
  a_tally_clr_cnt: assert property ( // R23
    (clr_any && cnt_ev) |=> s_r.tal == EER_RST_TAL + 16'h0001)
    else $error("tally not restarted by clear");

  // transaction framing
  a_cs_ends_read: assert property ( // R20
    (cs_rise && !cmd_ev) |=> s_r.mode == EER_IDLE)
    else $error("mode kept after cs high");
  a_read_holds: assert property ( // R20
    (in_rd && !cs_rise && !cmd_ev) |=> in_rd)
    else $error("read closed before cs high");

  // register read
  a_rd_evt: assert property ( // R24
    (rd_req && rd_addr == EER_ADR_EVT) |=> rd_hit && rd_data == $past(s_r.evt))
    else $error("event read wrong");
  a_rd_tal_low: assert property ( // R24
    (rd_req && rd_addr == EER_ADR_TAL0) |=> rd_hit && rd_data == $past(s_r.tal[7:0]))
    else $error("tally low byte read wrong");
  a_rd_trp_top: assert property ( // R24
    (rd_req && rd_addr == EER_ADR_TRP3) |=> rd_hit && rd_data == $past(s_r.trap[31:24]))
    else $error("trap top byte read wrong");
  a_rd_quiet: assert property ( // R24
    !rd_req |=> !rd_hit)
    else $error("read answer without request");

  c_tally_sat: cover property (cnt_ev && s_r.tal == EER_TAL_MAX);
  c_trap_take: cover property (trp_ev && !s_r.trp_tk);
  c_query_ans: cover property (dus_valid);
  c_clear_set: cover property (clr_any && sbc_ev);
  c_read_end: cover property (in_rd && cs_rise);
endmodule

// *** test_ecc_error_reporting.sv ***
// test_ecc_error_reporting: random and corner tests of eer_top
// assumes eer_host drives the link; read path and host reads driven here
`timescale 1ns/1ns
module test_ecc_error_reporting
  import eer_pkg::*;
();
  localparam logic [31:0] ADR [6] = '{EER_ADR_TRP0, EER_ADR_TRP1, EER_ADR_TRP2,
                                      EER_ADR_TRP3, EER_ADR_TAL0, EER_ADR_TAL1};
  logic        mclk, sys_rst, sck, cs_n, lk_cmd_v, unit_v, prog_req, prog_dirty;
  logic        prog_error, unit_off_set, dus_valid, rd_req, rd_hit;
  logic [2:0]  rsts;
  logic [3:0]  f;
  logic [7:0]  lk_cmd, cfg_v, cfg_n, dus, rd_data, evo;
  logic [15:0] talo;
  logic [31:0] uaddr, rd_addr, a0, w, trpo;
  int          n_errors, n_compared;

  always #50 mclk = ~mclk;

  eer_host i_host (.sck(sck), .cs_n(cs_n), .lk_cmd_v(lk_cmd_v), .lk_cmd(lk_cmd));
  eer_top i_dut (.mclk(mclk), .sys_rst(sys_rst), .sck(sck), .cs_n(cs_n),
    .soft_rst(rsts[0]), .hw_rst(rsts[1]), .cs_sig_rst(rsts[2]), .lk_cmd_v(lk_cmd_v),
    .lk_cmd(lk_cmd), .config_four_volatile(cfg_v), .config_four_nonvolatile(cfg_n),
    .unit_v(unit_v), .unit_addr(uaddr), .unit_sbc(f[3]), .unit_dbd(f[2]),
    .unit_main(f[1]), .unit_off(f[0]), .prog_req(prog_req), .prog_dirty(prog_dirty),
    .prog_error(prog_error), .unit_off_set(unit_off_set), .data_unit_ecc_status(dus),
    .dus_valid(dus_valid), .rd_req(rd_req), .rd_addr(rd_addr), .rd_data(rd_data),
    .rd_hit(rd_hit), .ecc_event_status(evo), .error_address_trap(trpo), .error_tally(talo));

  function automatic logic [7:0] f_dus(input logic ded, input logic [3:0] x);
    return {4'h0, x[2] & ded, 1'b0, x[3], x[0]};
  endfunction

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic rreg(input logic [31:0] a, input logic h);
    @(posedge mclk);
    rd_req  <= 1'b1;
    rd_addr <= a;
    @(posedge mclk);
    rd_req  <= 1'b0;
    #1;
    chk("hit", {31'h0, h}, {31'h0, rd_hit});
  endtask
  task automatic chkall(input logic [7:0] ev, input logic [31:0] tp, input logic [15:0] tl);
    rreg(EER_ADR_EVT, 1'b1);
    chk("event", {24'h0, ev}, {24'h0, rd_data & 8'h18});
    for (int i = 0; i < 6; i++) begin
      rreg(ADR[i], 1'b1);
      w = {rd_data, w[31:8]};
      if (i == 3)
        chk("trap", tp, w);
    end
    chk("tally", {16'h0, tl}, {16'h0, w[31:16]});
    chk("event_out", {24'h0, ev}, {24'h0, evo});
    chk("trap_out", tp, trpo);
    chk("tally_out", {16'h0, tl}, {16'h0, talo});
  endtask
  task automatic unit(input logic [31:0] a, input logic [3:0] x);
    @(posedge mclk);
    unit_v <= 1'b1;
    uaddr  <= a;
    f      <= x;
  endtask
  task automatic idle();
    @(posedge mclk);
    unit_v   <= 1'b0;
    prog_req <= 1'b0;
    #1;
  endtask
  task automatic frm(input logic [7:0] c);
    @(posedge mclk);
    i_host.start(c);
    cyc(6);
  endtask
  task automatic efrm();
    i_host.stop();
    cyc(6);
  endtask
  task automatic end_sim();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial begin
    #7500000;
    n_errors++;
    end_sim();
  end

  initial begin
    {mclk, unit_v, prog_req, prog_dirty, rd_req, rsts, f} = '0;
    {uaddr, rd_addr, w} = '0;
    sys_rst    = 1'b1;
    cfg_v      = 8'h08;
    cfg_n      = 8'h08;
    n_errors   = 0;
    n_compared = 0;
    void'($urandom(32'h512e));
    a0 = $urandom & 32'hFFFF_FFF0;
    cyc(5);
    sys_rst <= 1'b0;
    cyc(2);
    chkall(8'h00, 32'h0, 16'h0);
    rreg(32'h0080_0000, 1'b0);
    chk("unmapped", 32'h0, {24'h0, rd_data});
    frm(EER_OP_READ);
    unit(a0 | 32'h3, 4'b1010);
    unit(a0 | 32'h9, 4'b1010);
    unit(a0 + 32'h10, 4'b0110);
    unit(a0 + 32'h20, 4'b1000);
    idle();
    efrm();
    chkall(8'h18, a0 | 32'h3, 16'h2);
    frm(EER_OP_READ);
    unit(a0, 4'b1010);
    idle();
    efrm();
    chkall(8'h18, a0 | 32'h3, 16'h3);
    for (int i = 0; i < 8; i++) begin
      frm(i[0] ? EER_OP_QUERY2 : EER_OP_QUERY);
      cfg_v <= {4'h0, i[1], 3'h0};
      unit($urandom, 4'($urandom));
      idle();
      chk("dus_valid", 32'h1, {31'h0, dus_valid});
      chk("dus", {24'h0, f_dus(i[1], f)}, {24'h0, dus});
      efrm();
    end
    frm(8'h5A);
    unit(a0 + 32'h40, 4'b1010);
    idle();
    efrm();
    cfg_v <= 8'h08;
    chkall(8'h18, a0 | 32'h3, 16'h3);
    frm(EER_OP_CLEAR);
    efrm();
    chkall(8'h00, 32'h0, 16'h0);
    for (int k = 0; k < 3; k++) begin
      frm(EER_OP_READ);
      unit($urandom, 4'b0110);
      idle();
      efrm();
      rsts <= 3'b001 << k;
      @(posedge mclk);
      rsts <= 3'b000;
      cyc(2);
      chkall(8'h00, 32'h0, 16'h0);
    end
    cfg_n <= 8'h00;
    frm(EER_OP_READ);
    unit(a0, 4'b1010);
    unit(a0 + 32'h10, 4'b0110);
    idle();
    efrm();
    chkall(8'h18, a0 + 32'h10, 16'h2);
    frm(EER_OP_CLEAR);
    efrm();
    cfg_v <= 8'h00;
    frm(EER_OP_READ);
    unit(a0, 4'b1011);
    idle();
    efrm();
    chkall(8'h00, 32'h0, 16'h0);
    for (int d = 0; d < 2; d++) begin
      cfg_v <= {4'h0, d[0], 3'h0};
      @(posedge mclk);
      prog_req   <= 1'b1;
      prog_dirty <= 1'b1;
      idle();
      chk("prog_error", d, {31'h0, prog_error});
      chk("unit_off_set", {31'h0, ~d[0]}, {31'h0, unit_off_set});
    end
    cfg_v <= 8'h08;
    cfg_n <= 8'h08;
    frm(EER_OP_READ);
    for (int i = 0; i < 65537; i++)
      unit(a0 + {i[27:0], 4'h0}, 4'b1010);
    idle();
    efrm();
    chkall(8'h08, a0, 16'hFFFF);
    end_sim();
  end
endmodule
